/* File: hw/ssis_defines.svh */
// Offsets, field positions, reset values and limits of the sequence input selector.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef SSIS_DEFINES_SVH
`define SSIS_DEFINES_SVH

`define SSIS_AW            8
`define SSIS_OFS_CTRL      8'h00
`define SSIS_OFS_LOCK      8'h04
`define SSIS_OFS_TLIM12    8'h08
`define SSIS_OFS_TLIMEXT   8'h0c
`define SSIS_OFS_INERTIA   8'h10
`define SSIS_OFS_INSEL_LO  8'h14
`define SSIS_OFS_INSEL_HI  8'h18
`define SSIS_OFS_STATUS    8'h1c

`define SSIS_CTRL_ZS       1:0
`define SSIS_CTRL_SDIR     4
`define SSIS_CTRL_SPINV    5
`define SSIS_CTRL_TDIR     8
`define SSIS_CTRL_TPINV    9
`define SSIS_CTRL_ROT      12
`define SSIS_CTRL_TORQUE_LIMIT_SWITCH    19:16
`define SSIS_CTRL_STOPSEL  27:24

`define SSIS_CTRL_RST      32'h0000_0000
`define SSIS_LOCK_RST      16'h000a
`define SSIS_TLIM_RST      16'h0bb8
`define SSIS_INERTIA_RST   16'h00fa
`define SSIS_INSEL_RST     40'h00_0000_0000

`define SSIS_NTERM         10
`define SSIS_NFUNC         6
`define SSIS_LOCK_MARGIN   17'h0000a
`define SSIS_SPEED_MAX     16'h4e20
`define SSIS_TORQUE_LIMIT_SWITCH_SWITCH  4'h3
`define SSIS_TORQUE_LIMIT_SWITCH_SPLIT   4'h6

`endif

/* File: hw/ssis_pkg.sv */
// Types shared by the sequence input selector files.
// Assumes ssis_defines.svh is on the include path.
`include "ssis_defines.svh"

package ssis_pkg;

  typedef enum logic [1:0] {
    SSIS_ZS_OFF        = 2'b00,
    SSIS_ZS_CLAMP      = 2'b01,
    SSIS_ZS_CLAMP_LOCK = 2'b10,
    SSIS_ZS_LOCK       = 2'b11
  } ssis_zs_e;

  // Terminal assignment codes; bit k of the function vector is code k+1
  typedef enum logic [2:0] {
    SSIS_FN_NONE  = 3'b000,
    SSIS_FN_ZERO  = 3'b001,
    SSIS_FN_SPEED_SIGN_INPUT = 3'b010,
    SSIS_FN_TLSW  = 3'b011,
    SSIS_FN_TORQUE_SIGN_INPUT = 3'b100,
    SSIS_FN_STOP  = 3'b101,
    SSIS_FN_INERTIA_SELECT_INPUT  = 3'b110
  } ssis_fn_e;

  typedef struct packed {
    logic [`SSIS_NTERM-1:0] sync1;
    logic [`SSIS_NTERM-1:0] sync2;
  } ssis_sync_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] lock_lvl;
    logic [15:0] tlim_one;
    logic [15:0] tlim_two;
    logic [15:0] tlim_fwd_ext;
    logic [15:0] tlim_rev_ext;
    logic [15:0] inertia_one;
    logic [15:0] inertia_two;
    logic [39:0] in_sel;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    logic [15:0] spd_mag;
    logic        spd_rev;
    logic        spd_ccw;
    logic        zero_clamp;
    logic        servo_lock;
    logic [15:0] trq_mag;
    logic        trq_rev;
    logic        trq_ccw;
    logic [15:0] lim_fwd;
    logic [15:0] lim_rev;
    logic        ext_alarm;
    logic [3:0]  stop_method;
    logic [15:0] inertia;
  } ssis_main_s;

endpackage

/* File: hw/ssis_input_map.sv */
// Synchronises the ten sequence terminals and maps them onto functions.
// Assumes terminals are asynchronous to pclk; one 4-bit setting per terminal.
`timescale 1ns/1ps
`default_nettype none
`include "ssis_defines.svh"

module ssis_input_map (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`SSIS_NTERM-1:0]  term_in,
  input  wire logic [39:0]             in_sel,
  output logic      [`SSIS_NFUNC-1:0]  func_o
);

  ssis_pkg::ssis_sync_s state_reg;
  ssis_pkg::ssis_sync_s state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = term_in;
    state_next.sync2 = state_reg.sync1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    func_o = '0;
    for (int t = 0; t < `SSIS_NTERM; t++) begin
      for (int f = 0; f < `SSIS_NFUNC; f++) begin
        if (in_sel[4*t +: 3] == 3'(f + 1)) begin
          func_o[f] = func_o[f] | (state_reg.sync2[t] ^ in_sel[4*t + 3]);
        end
      end
    end
  end

endmodule // ssis_input_map
`default_nettype wire

/* File: hw/ssis_selector.sv */
// Sequence input selector: zero-speed clamp, direction, torque limit,
// emergency stop and inertia selection, configured over APB.
// Assumes APB3 full-word writes, 40 MHz pclk, speeds in 1 r/min units.
`timescale 1ns/1ps
`default_nettype none
`include "ssis_defines.svh"

// Behaviour
// - Zero-speed selection 0 ignores, 1 clamps
// - Selection 2 clamps, locks at low actual speed
// - Selection 3 locks at or below level minus 10
// - Speed direction selection resets to disabled
// - Selection 1: sign input sets speed direction
// - Selection 0: analog polarity, optionally inverted
// - Internal speed sign sets direction, 20000 max
// - Limit switch: selection 3 picks one/two
// - Selection 6: split limits or external limits
// - Torque direction selection resets to disabled
// - Selection 1: torque sign input sets direction
// - Selection 0: torque polarity, optionally inverted
// - Rotation setting maps direction to CW/CCW
// - Emergency stop raises external alarm stop
// - Inertia switch picks ratio one or two
// - Ten settings assign terminals and polarity
module ssis_selector (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SSIS_AW-1:0]     paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [`SSIS_NTERM-1:0]  seq_terminals,
  input  wire logic                    speed_src_analog,
  input  wire logic signed [15:0]      analog_speed_command,
  input  wire logic signed [15:0]      internal_speed_command,
  input  wire logic signed [15:0]      actual_speed,
  input  wire logic signed [15:0]      analog_torque_command,
  output logic      [15:0]             speed_cmd_mag,
  output logic                         speed_cmd_rev,
  output logic                         speed_motor_ccw,
  output logic                         zero_speed_clamp,
  output logic                         servo_lock,
  output logic      [15:0]             torque_cmd_mag,
  output logic                         torque_cmd_rev,
  output logic                         torque_motor_ccw,
  output logic      [15:0]             torque_limit_fwd,
  output logic      [15:0]             torque_limit_rev,
  output logic                         external_alarm,
  output logic      [3:0]              alarm_stop_method,
  output logic      [15:0]             inertia_ratio
);

  ssis_pkg::ssis_main_s  state_reg;
  ssis_pkg::ssis_main_s  state_next;
  logic [`SSIS_NFUNC-1:0] fn;
  logic [15:0]            cmd_mag;
  logic [15:0]            act_mag;

  // Magnitude of a signed speed or torque; -32768 still fits unsigned
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Word-aligned offset; the two low address bits are ignored
  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  ssis_input_map u_map (
    .pclk    (pclk),
    .presetn (presetn),
    .term_in (seq_terminals),
    .in_sel  (state_reg.in_sel),
    .func_o  (fn)
  );

  wire logic zero_req  = fn[0];
  wire logic spd_sign  = fn[1];
  wire logic tl_switch = fn[2];
  wire logic trq_sign  = fn[3];
  wire logic estop     = fn[4];
  wire logic inertia_select_input      = fn[5];

  wire ssis_pkg::ssis_zs_e zs_mode = ssis_pkg::ssis_zs_e'(state_reg.ctrl[`SSIS_CTRL_ZS]);
  wire logic       sdir_sel = state_reg.ctrl[`SSIS_CTRL_SDIR];
  wire logic       sp_inv   = state_reg.ctrl[`SSIS_CTRL_SPINV];
  wire logic       tdir_sel = state_reg.ctrl[`SSIS_CTRL_TDIR];
  wire logic       tp_inv   = state_reg.ctrl[`SSIS_CTRL_TPINV];
  wire logic       rot_dir  = state_reg.ctrl[`SSIS_CTRL_ROT];
  wire logic [3:0] tl_sel   = state_reg.ctrl[`SSIS_CTRL_TORQUE_LIMIT_SWITCH];

  // source magnitude clamped to the speed range
  always_comb begin
    cmd_mag = speed_src_analog ? abs16(analog_speed_command)
                               : abs16(internal_speed_command);
    if (cmd_mag > `SSIS_SPEED_MAX) begin
      cmd_mag = `SSIS_SPEED_MAX;
    end
    act_mag = abs16(actual_speed);
  end

  always_comb begin
    logic       addr_ok;
    logic [5:0] idx;
    addr_ok    = 1'b0;
    idx        = paddr[7:2];
    state_next = state_reg;

    // Zero wait states: ready is raised for the access cycle only
    state_next.ready  = psel & ~penable;
    state_next.slverr = 1'b0;
    state_next.rdata  = '0;
    addr_ok = (idx <= 6'(`SSIS_OFS_STATUS >> 2));
    if (psel && !penable) begin
      state_next.slverr = !addr_ok;
      unique case (word_ofs(paddr))
        `SSIS_OFS_CTRL:     state_next.rdata = state_reg.ctrl;
        `SSIS_OFS_LOCK:     state_next.rdata = {16'h0000, state_reg.lock_lvl};
        `SSIS_OFS_TLIM12:   state_next.rdata = {state_reg.tlim_two, state_reg.tlim_one};
        `SSIS_OFS_TLIMEXT:  state_next.rdata = {state_reg.tlim_rev_ext, state_reg.tlim_fwd_ext};
        `SSIS_OFS_INERTIA:  state_next.rdata = {state_reg.inertia_two, state_reg.inertia_one};
        `SSIS_OFS_INSEL_LO: state_next.rdata = state_reg.in_sel[31:0];
        `SSIS_OFS_INSEL_HI: state_next.rdata = {24'h000000, state_reg.in_sel[39:32]};
        `SSIS_OFS_STATUS:   state_next.rdata = {19'h00000, state_reg.ext_alarm,
                                                state_reg.servo_lock, state_reg.zero_clamp,
                                                state_reg.trq_rev, state_reg.spd_rev,
                                                2'b00, fn};
        default:            state_next.rdata = '0;
      endcase
    end

    // Writes land at the access edge only; the status word is read-only
    if (psel && penable && state_reg.ready && pwrite && !state_reg.slverr) begin
      unique case (word_ofs(paddr))
        `SSIS_OFS_CTRL:     state_next.ctrl = pwdata & 32'h0f0f_1333;
        `SSIS_OFS_LOCK:     state_next.lock_lvl = pwdata[15:0];
        `SSIS_OFS_TLIM12: begin
          state_next.tlim_one = pwdata[15:0];
          state_next.tlim_two = pwdata[31:16];
        end
        `SSIS_OFS_TLIMEXT: begin
          state_next.tlim_fwd_ext = pwdata[15:0];
          state_next.tlim_rev_ext = pwdata[31:16];
        end
        `SSIS_OFS_INERTIA: begin
          state_next.inertia_one = pwdata[15:0];
          state_next.inertia_two = pwdata[31:16];
        end
        `SSIS_OFS_INSEL_LO: state_next.in_sel[31:0]  = pwdata;
        `SSIS_OFS_INSEL_HI: state_next.in_sel[39:32] = pwdata[7:0];
        default: ;
      endcase
    end

    if (sdir_sel) begin
      state_next.spd_rev = spd_sign;
    end else if (speed_src_analog) begin
      state_next.spd_rev = analog_speed_command[15] ^ sp_inv;
    end else begin
      state_next.spd_rev = internal_speed_command[15];
    end

    // clamp for selections 1 and 2
    state_next.zero_clamp = zero_req &&
      (zs_mode == ssis_pkg::SSIS_ZS_CLAMP || zs_mode == ssis_pkg::SSIS_ZS_CLAMP_LOCK);
    state_next.spd_mag = state_next.zero_clamp ? 16'h0000 : cmd_mag;
    unique case (zs_mode)
      ssis_pkg::SSIS_ZS_OFF,
      ssis_pkg::SSIS_ZS_CLAMP:      state_next.servo_lock = 1'b0;
      ssis_pkg::SSIS_ZS_CLAMP_LOCK: state_next.servo_lock =
                                      zero_req && (act_mag <= state_reg.lock_lvl);
      ssis_pkg::SSIS_ZS_LOCK:       state_next.servo_lock = zero_req &&
        ({1'b0, cmd_mag} + `SSIS_LOCK_MARGIN <= {1'b0, state_reg.lock_lvl});
    endcase

    if (tdir_sel) begin
      state_next.trq_rev = trq_sign;
    end else begin
      state_next.trq_rev = analog_torque_command[15] ^ tp_inv;
    end
    state_next.trq_mag = abs16(analog_torque_command);

    state_next.spd_ccw = state_next.spd_rev ^ rot_dir;
    state_next.trq_ccw = state_next.trq_rev ^ rot_dir;

    // switch acts only for 3 and 6
    state_next.lim_fwd = state_reg.tlim_one;
    state_next.lim_rev = state_reg.tlim_one;
    if (tl_sel == `SSIS_TORQUE_LIMIT_SWITCH_SWITCH && tl_switch) begin
      state_next.lim_fwd = state_reg.tlim_two;
      state_next.lim_rev = state_reg.tlim_two;
    end else if (tl_sel == `SSIS_TORQUE_LIMIT_SWITCH_SPLIT) begin
      state_next.lim_fwd = tl_switch ? state_reg.tlim_fwd_ext : state_reg.tlim_one;
      state_next.lim_rev = tl_switch ? state_reg.tlim_rev_ext : state_reg.tlim_two;
    end

    state_next.ext_alarm   = estop;
    state_next.stop_method = state_reg.ctrl[`SSIS_CTRL_STOPSEL];

    state_next.inertia = inertia_select_input ? state_reg.inertia_two : state_reg.inertia_one;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg              <= '0;
      state_reg.ctrl         <= `SSIS_CTRL_RST;
      state_reg.lock_lvl     <= `SSIS_LOCK_RST;
      state_reg.tlim_one     <= `SSIS_TLIM_RST;
      state_reg.tlim_two     <= `SSIS_TLIM_RST;
      state_reg.tlim_fwd_ext <= `SSIS_TLIM_RST;
      state_reg.tlim_rev_ext <= `SSIS_TLIM_RST;
      state_reg.inertia_one  <= `SSIS_INERTIA_RST;
      state_reg.inertia_two  <= `SSIS_INERTIA_RST;
      state_reg.in_sel       <= `SSIS_INSEL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata            = state_reg.rdata;
  assign pready            = state_reg.ready;
  assign pslverr           = state_reg.slverr;
  assign speed_cmd_mag     = state_reg.spd_mag;
  assign speed_cmd_rev     = state_reg.spd_rev;
  assign speed_motor_ccw   = state_reg.spd_ccw;
  assign zero_speed_clamp  = state_reg.zero_clamp;
  assign servo_lock        = state_reg.servo_lock;
  assign torque_cmd_mag    = state_reg.trq_mag;
  assign torque_cmd_rev    = state_reg.trq_rev;
  assign torque_motor_ccw  = state_reg.trq_ccw;
  assign torque_limit_fwd  = state_reg.lim_fwd;
  assign torque_limit_rev  = state_reg.lim_rev;
  assign external_alarm    = state_reg.ext_alarm;
  assign alarm_stop_method = state_reg.stop_method;
  assign inertia_ratio     = state_reg.inertia;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_clamp_on: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_CLAMP && zero_req |=> speed_cmd_mag == 16'h0000 && zero_speed_clamp)
    else $error("zero-speed clamp not applied");
  a_zero_sel_off: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_OFF |=> !zero_speed_clamp && !servo_lock)
    else $error("zero-speed input acted while disabled");
  a_lock_actual_spd: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_CLAMP_LOCK && zero_req
    |=> servo_lock == ($past(act_mag) <= $past(state_reg.lock_lvl)) && speed_cmd_mag == 16'h0000)
    else $error("servo lock on actual speed wrong");
  a_lock_cmd_margin: assert property (
    servo_lock && $past(zs_mode) == ssis_pkg::SSIS_ZS_LOCK
    |-> 17'($past(cmd_mag)) + 17'd10 <= 17'($past(state_reg.lock_lvl)))
    else $error("servo lock above level minus margin");
  a_speed_sign_in: assert property (
    sdir_sel |=> speed_cmd_rev == $past(spd_sign))
    else $error("speed sign input ignored");
  a_speed_max: assert property (
    speed_cmd_mag <= 16'h4e20)
    else $error("speed magnitude above range");
  a_tlim_sel_three: assert property (
    tl_sel == 4'h3 && tl_switch |=> torque_limit_fwd == $past(state_reg.tlim_two)
                                    && torque_limit_rev == $past(state_reg.tlim_two))
    else $error("limit two not selected");
  a_tlim_sel_six: assert property (
    tl_sel == 4'h6 && !tl_switch |=> torque_limit_fwd == $past(state_reg.tlim_one)
                                     && torque_limit_rev == $past(state_reg.tlim_two))
    else $error("split limits not applied");
  a_torque_sign_in: assert property (
    tdir_sel |=> torque_cmd_rev == $past(trq_sign))
    else $error("torque sign input ignored");
  a_rotation_map: assert property (
    speed_motor_ccw == (speed_cmd_rev ^ $past(rot_dir)))
    else $error("speed rotation sense wrong");
  a_estop_alarm: assert property (
    $rose(estop) |=> external_alarm ##0 alarm_stop_method == $past(state_reg.ctrl[27:24]))
    else $error("emergency stop not raised");
  a_inertia_pick: assert property (
    inertia_select_input |=> inertia_ratio == $past(state_reg.inertia_two))
    else $error("inertia ratio two not used");

  // Opposite cases and the torque rotation map, so a stuck output cannot pass
  a_rot_map_torque: assert property (
    torque_motor_ccw == (torque_cmd_rev ^ $past(rot_dir)))
    else $error("torque rotation sense wrong");
  a_zero_sel_lock: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_CLAMP_LOCK && !zero_req |=> !zero_speed_clamp && !servo_lock)
    else $error("clamp or lock without request");
  a_lock_no_clamp: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_LOCK |=> !zero_speed_clamp)
    else $error("lock-only selection clamped the speed");
  a_lock_margin_hit: assert property (
    zs_mode == ssis_pkg::SSIS_ZS_LOCK && zero_req
    && 17'(cmd_mag) + 17'h0000a <= 17'(state_reg.lock_lvl) |=> servo_lock)
    else $error("servo lock missing below margin");
  a_speed_polarity: assert property (
    !sdir_sel && speed_src_analog
    |=> speed_cmd_rev == ($past(analog_speed_command[15]) ^ $past(sp_inv)))
    else $error("analog speed polarity not followed");
  a_speed_internal: assert property (
    !sdir_sel && !speed_src_analog |=> speed_cmd_rev == $past(internal_speed_command[15]))
    else $error("internal speed sign not followed");
  a_torque_polarity: assert property (
    !tdir_sel |=> torque_cmd_rev == ($past(analog_torque_command[15]) ^ $past(tp_inv)))
    else $error("torque polarity not followed");
  a_tlim_three_off: assert property (
    tl_sel == 4'h3 && !tl_switch |=> torque_limit_fwd == $past(state_reg.tlim_one)
      && torque_limit_rev == $past(state_reg.tlim_one))
    else $error("limit one not selected");
  a_tlim_default: assert property (
    tl_sel != 4'h3 && tl_sel != 4'h6 |=> torque_limit_fwd == $past(state_reg.tlim_one)
      && torque_limit_rev == $past(state_reg.tlim_one))
    else $error("limit switch acted outside its selections");
  a_tlim_external: assert property (
    tl_sel == 4'h6 && tl_switch |=> torque_limit_fwd == $past(state_reg.tlim_fwd_ext)
      && torque_limit_rev == $past(state_reg.tlim_rev_ext))
    else $error("external limits not applied");
  a_estop_clear: assert property (
    !estop |=> !external_alarm)
    else $error("alarm without emergency stop");
  a_inertia_one: assert property (
    !inertia_select_input |=> inertia_ratio == $past(state_reg.inertia_one))
    else $error("inertia ratio one not used");

endmodule // ssis_selector
`default_nettype wire

/* File: testbench/ssis_host_model.sv */
// Host controller model: drives the ten sequence terminals as plain levels.
// Assumes the bench names the wanted levels; pins move just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module ssis_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [9:0] want,
  output logic      [9:0] seq_terminals
);
  // Pins held low while the drive is in reset, as an idle controller would
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_terminals <= 10'h000;
    end else begin
      seq_terminals <= want;
    end
  end
endmodule // ssis_host_model

`default_nettype wire

/* File: testbench/test_servo_sequence_input_selector.sv */
// Self-checking bench for the sequence input selector.
// Assumes zero-wait APB, a host model on the terminals, 40 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
`include "ssis_defines.svh"

module test_servo_sequence_input_selector;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic        [9:0]  want, seq_terminals;
  logic               speed_src_analog, speed_cmd_rev, speed_motor_ccw, zero_speed_clamp;
  logic               servo_lock, torque_cmd_rev, torque_motor_ccw, external_alarm;
  logic signed [15:0] analog_speed_command, internal_speed_command, actual_speed;
  logic signed [15:0] analog_torque_command;
  logic        [15:0] speed_cmd_mag, torque_cmd_mag, torque_limit_fwd, torque_limit_rev;
  logic        [15:0] inertia_ratio;
  logic        [3:0]  alarm_stop_method;
  int                 miscompares, n_checks;

  ssis_host_model i_host (.pclk(pclk), .presetn(presetn), .want(want),
    .seq_terminals(seq_terminals));

  ssis_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_terminals(seq_terminals), .speed_src_analog(speed_src_analog),
    .analog_speed_command(analog_speed_command), .internal_speed_command(internal_speed_command),
    .actual_speed(actual_speed), .analog_torque_command(analog_torque_command),
    .speed_cmd_mag(speed_cmd_mag), .speed_cmd_rev(speed_cmd_rev),
    .speed_motor_ccw(speed_motor_ccw), .zero_speed_clamp(zero_speed_clamp),
    .servo_lock(servo_lock), .torque_cmd_mag(torque_cmd_mag), .torque_cmd_rev(torque_cmd_rev),
    .torque_motor_ccw(torque_motor_ccw), .torque_limit_fwd(torque_limit_fwd),
    .torque_limit_rev(torque_limit_rev), .external_alarm(external_alarm),
    .alarm_stop_method(alarm_stop_method), .inertia_ratio(inertia_ratio));

  always #12.5 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is sampled high; a hung slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    bit got;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer read 1 ns into the access cycle, before the edge that ends the access
    for (i = 0; i < 16; i++) begin
      #1;
      got = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      if (got) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  // Terminal path needs three edges plus the host model's own edge
  task automatic settle();
    repeat (5) @(posedge pclk);
    #1;
  endtask

  task automatic t_reset();
    settle();
    chk("limit_fwd", torque_limit_fwd, 32'h0000_0bb8);
    chk("inertia", inertia_ratio, 32'h0000_00fa);
    apb(1'b0, `SSIS_OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, `SSIS_OFS_LOCK, 32'h0);
    chk("lock", rd, 32'h0000_000a);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", err, 32'h1);
  endtask

  // Term6 inverted stop, term9 code 7 which must do nothing
  task automatic t_map();
    apb(1'b1, `SSIS_OFS_INSEL_LO, 32'h0d65_4321);
    apb(1'b1, `SSIS_OFS_INSEL_HI, 32'h0000_0070);
    apb(1'b0, `SSIS_OFS_INSEL_LO, 32'h0);
    chk("insel", rd, 32'h0d65_4321);
  endtask

  task automatic t_zero();
    int zs[7] = '{0, 1, 2, 2, 3, 3, 1};
    int sp[7] = '{100, 100, 100, 100, 0, 1, 100};
    int ac[7] = '{5, 5, 5, 11, 50, 50, 5};
    bit zi[7] = '{1, 1, 1, 1, 1, 1, 0};
    bit cl[7] = '{0, 1, 1, 1, 0, 0, 0};
    bit lk[7] = '{0, 0, 1, 0, 1, 0, 0};
    for (int k = 0; k < 7; k++) begin
      @(posedge pclk);
      speed_src_analog <= 1'b0;
      internal_speed_command <= 16'(sp[k]);
      actual_speed <= 16'(ac[k]);
      want[0] <= zi[k];
      apb(1'b1, `SSIS_OFS_CTRL, 32'(zs[k]));
      settle();
      chk("zero_clamp", zero_speed_clamp, 32'(cl[k]));
      chk("servo_lock", servo_lock, 32'(lk[k]));
      chk("speed_mag", speed_cmd_mag, cl[k] ? 32'h0 : 32'(sp[k]));
    end
    @(posedge pclk);
    want[0] <= 1'b0;
  endtask

  task automatic spd(input bit src, sdir, spinv, rot, sgn, input int v, input bit rev);
    int m;
    m = (v < 0) ? -v : v;
    if (m > 20000) m = 20000;
    @(posedge pclk);
    speed_src_analog <= src;
    analog_speed_command <= 16'(src ? v : -v);
    internal_speed_command <= 16'(src ? -v : v);
    want[1] <= sgn;
    apb(1'b1, `SSIS_OFS_CTRL, (32'(sdir) << 4) | (32'(spinv) << 5) | (32'(rot) << 12));
    settle();
    chk("speed_rev", speed_cmd_rev, 32'(rev));
    chk("speed_ccw", speed_motor_ccw, 32'(rev ^ rot));
    chk("speed_mag", speed_cmd_mag, 32'(m));
  endtask

  task automatic trq(input bit tdir, tpinv, rot, sgn, input int v, input bit rev);
    @(posedge pclk);
    analog_torque_command <= 16'(v);
    want[3] <= sgn;
    apb(1'b1, `SSIS_OFS_CTRL, (32'(tdir) << 8) | (32'(tpinv) << 9) | (32'(rot) << 12));
    settle();
    chk("torque_rev", torque_cmd_rev, 32'(rev));
    chk("torque_ccw", torque_motor_ccw, 32'(rev ^ rot));
    chk("torque_mag", torque_cmd_mag, 32'((v < 0) ? -v : v));
  endtask

  task automatic lim(input int tl, input bit sw, input logic [15:0] f, r);
    @(posedge pclk);
    want[2] <= sw;
    apb(1'b1, `SSIS_OFS_CTRL, 32'(tl) << 16);
    settle();
    chk("limit_fwd", torque_limit_fwd, 32'(f));
    chk("limit_rev", torque_limit_rev, 32'(r));
  endtask

  task automatic t_stop();
    apb(1'b1, `SSIS_OFS_CTRL, 32'h0500_0000);
    want[4] <= 1'b1;
    settle();
    chk("alarm", external_alarm, 32'h1);
    chk("stop_method", alarm_stop_method, 32'h5);
    apb(1'b0, `SSIS_OFS_STATUS, 32'h0);
    chk("status_alarm", rd[12], 32'h1);
    want[4] <= 1'b0;
    want[6] <= 1'b0;
    settle();
    chk("alarm_inverted", external_alarm, 32'h1);
    @(posedge pclk);
    want[6] <= 1'b1;
    settle();
    chk("alarm_clear", external_alarm, 32'h0);
  endtask

  task automatic t_inertia();
    apb(1'b1, `SSIS_OFS_INERTIA, 32'h0123_0045);
    settle();
    chk("inertia_one", inertia_ratio, 32'h0045);
    @(posedge pclk);
    want[5] <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("inertia_early", inertia_ratio, 32'h0045);
    repeat (2) @(posedge pclk);
    #1;
    chk("inertia_two", inertia_ratio, 32'h0123);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 10'h3c0;
    speed_src_analog = 1'b0;
    analog_speed_command = 16'sh0000;
    internal_speed_command = 16'sh0000;
    actual_speed = 16'sh0000;
    analog_torque_command = 16'sh0000;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    presetn = 1'b1;
    t_reset();
    t_map();
    t_zero();
    spd(1, 0, 0, 0, 1, 500, 0);
    spd(1, 0, 0, 0, 0, -500, 1);
    spd(1, 0, 1, 0, 0, 500, 1);
    spd(1, 0, 1, 1, 0, -500, 0);
    spd(0, 0, 0, 0, 0, -25000, 1);
    spd(0, 0, 0, 1, 0, 20000, 0);
    spd(0, 1, 0, 0, 0, -300, 0);
    spd(1, 1, 0, 1, 1, 300, 1);
    trq(0, 0, 0, 1, 700, 0);
    trq(0, 0, 0, 0, -700, 1);
    trq(0, 1, 0, 0, 700, 1);
    trq(0, 1, 1, 0, -700, 0);
    trq(1, 0, 0, 0, -700, 0);
    trq(1, 1, 1, 1, 700, 1);
    apb(1'b1, `SSIS_OFS_TLIM12, 32'h0200_0100);
    apb(1'b1, `SSIS_OFS_TLIMEXT, 32'h0400_0300);
    lim(3, 0, 16'h0100, 16'h0100);
    lim(3, 1, 16'h0200, 16'h0200);
    lim(6, 0, 16'h0100, 16'h0200);
    lim(6, 1, 16'h0300, 16'h0400);
    lim(0, 1, 16'h0100, 16'h0100);
    t_stop();
    t_inertia();
    tally_and_finish();
  end
endmodule // test_servo_sequence_input_selector

`default_nettype wire
